// file: vtlcs_params.svh
// constants for the vector table lock and context select block
`ifndef VTLCS_PARAMS_SVH
`define VTLCS_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------
`define VTLCS_OFS_ORIGIN_UPPER 12'h000
`define VTLCS_OFS_ORIGIN_HIGH 12'h004
`define VTLCS_OFS_ORIGIN_LOW 12'h008
`define VTLCS_OFS_PTR_UPPER 12'h00C
`define VTLCS_OFS_PTR_HIGH 12'h010
`define VTLCS_OFS_PTR_LOW 12'h014
`define VTLCS_OFS_LOCK 12'h018
`define VTLCS_OFS_BANK_CTL 12'h01C
`define VTLCS_OFS_UNLOCK_KEY 12'h020

// ----------------------------------------------------------------
// widths and field layout
// ----------------------------------------------------------------
`define VTLCS_ADDR_W 12
`define VTLCS_VEC_W 21
`define VTLCS_UPPER_W 5
`define VTLCS_UPPER_MSB 20
`define VTLCS_UPPER_LSB 16
`define VTLCS_HIGH_MSB 15
`define VTLCS_HIGH_LSB 8
`define VTLCS_LOW_MSB 7
`define VTLCS_LOW_LSB 0
`define VTLCS_FLAG_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VTLCS_ORIGIN_RST 21'h000008
`define VTLCS_PTR_RST 21'h000008
`define VTLCS_LOCK_RST 1'b0
`define VTLCS_BANK_RST 1'b0

// ----------------------------------------------------------------
// protected-write key bytes
// ----------------------------------------------------------------
`define VTLCS_KEY_FIRST 8'h55
`define VTLCS_KEY_SECOND 8'hAA

`endif

// file: vtlcs_pkg.sv
// types for the vector table lock and context select block
package vtlcs_pkg;

  // ----------------------------------------------------------------
  // unlock sequence states, gray along idle, first, armed
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VTLCS_KEY_IDLE = 2'b00,
    VTLCS_KEY_FIRST_SEEN = 2'b01,
    VTLCS_KEY_ARMED = 2'b11
  } vtlcs_key_t;

  // ----------------------------------------------------------------
  // whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [20:0] origin;
    logic [20:0] pointer;
    logic locked;
    logic bank_sel;
    vtlcs_key_t key;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vtlcs_state_t;

endpackage : vtlcs_pkg

// file: vtlcs_top.sv
// vector table lock and context select register block, apb slave
`timescale 1ns/1ps
`include "vtlcs_params.svh"

module vtlcs_top
  import vtlcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vector_pointer_load,
  input wire logic [20:0] vector_pointer_in,
  input wire logic one_way_lock_option,
  output logic [20:0] vector_table_origin,
  output logic base_locked_flag,
  output logic saved_context_bank_select
);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  vtlcs_state_t state_reg;
  vtlcs_state_t state_next;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic access_first;
  logic access_done;
  logic wr_done;
  logic lane0;
  logic [7:0] wbyte;
  logic hit_origin_upper;
  logic hit_origin_high;
  logic hit_origin_low;
  logic hit_ptr_upper;
  logic hit_ptr_high;
  logic hit_ptr_low;
  logic hit_lock;
  logic hit_bank;
  logic hit_key;
  logic mapped;
  logic origin_wr_ok;
  logic lock_wr_ok;
  logic [7:0] rd_byte;

  // answer one cycle into the access phase so every output is a flop
  assign access_first = psel & penable & ~state_reg.pready;
  assign access_done = psel & penable & state_reg.pready;
  assign wr_done = access_done & pwrite & ~state_reg.pslverr;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];

  assign hit_origin_upper = (paddr == `VTLCS_OFS_ORIGIN_UPPER);
  assign hit_origin_high = (paddr == `VTLCS_OFS_ORIGIN_HIGH);
  assign hit_origin_low = (paddr == `VTLCS_OFS_ORIGIN_LOW);
  assign hit_ptr_upper = (paddr == `VTLCS_OFS_PTR_UPPER);
  assign hit_ptr_high = (paddr == `VTLCS_OFS_PTR_HIGH);
  assign hit_ptr_low = (paddr == `VTLCS_OFS_PTR_LOW);
  assign hit_lock = (paddr == `VTLCS_OFS_LOCK);
  assign hit_bank = (paddr == `VTLCS_OFS_BANK_CTL);
  assign hit_key = (paddr == `VTLCS_OFS_UNLOCK_KEY);

  assign mapped = hit_origin_upper | hit_origin_high | hit_origin_low |
                  hit_ptr_upper | hit_ptr_high | hit_ptr_low |
                  hit_lock | hit_bank | hit_key;

  // origin bytes only change while the lock is open
  assign origin_wr_ok = wr_done & lane0 & ~state_reg.locked;

  // the lock only moves on the write right after the key pair
  assign lock_wr_ok = wr_done & lane0 & hit_lock &
                      (state_reg.key == VTLCS_KEY_ARMED);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (hit_origin_upper) begin
      rd_byte = {3'h0, state_reg.origin[`VTLCS_UPPER_MSB:`VTLCS_UPPER_LSB]};
    end else if (hit_origin_high) begin
      rd_byte = state_reg.origin[`VTLCS_HIGH_MSB:`VTLCS_HIGH_LSB];
    end else if (hit_origin_low) begin
      rd_byte = state_reg.origin[`VTLCS_LOW_MSB:`VTLCS_LOW_LSB];
    end else if (hit_ptr_upper) begin
      rd_byte = {3'h0, state_reg.pointer[`VTLCS_UPPER_MSB:`VTLCS_UPPER_LSB]};
    end else if (hit_ptr_high) begin
      rd_byte = state_reg.pointer[`VTLCS_HIGH_MSB:`VTLCS_HIGH_LSB];
    end else if (hit_ptr_low) begin
      rd_byte = state_reg.pointer[`VTLCS_LOW_MSB:`VTLCS_LOW_LSB];
    end else if (hit_lock) begin
      rd_byte = {7'h00, state_reg.locked};
    end else if (hit_bank) begin
      rd_byte = {7'h00, state_reg.bank_sel};
    end else begin
      // key register reads back zero so the key never leaks
      rd_byte = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // bus handshake
    state_next.pready = access_first;
    if (access_first) begin
      state_next.pslverr = ~mapped;
      state_next.prdata = (mapped && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end else if (access_done) begin
      state_next.pslverr = 1'b0;
      state_next.prdata = 32'h00000000;
    end

    // active pointer follows the vectoring logic, software cannot write it
    if (vector_pointer_load) begin
      state_next.pointer = vector_pointer_in;
    end

    // writable origin, held as three bytes
    if (origin_wr_ok && hit_origin_upper) begin
      state_next.origin[`VTLCS_UPPER_MSB:`VTLCS_UPPER_LSB] = wbyte[4:0];
    end
    if (origin_wr_ok && hit_origin_high) begin
      state_next.origin[`VTLCS_HIGH_MSB:`VTLCS_HIGH_LSB] = wbyte;
    end
    if (origin_wr_ok && hit_origin_low) begin
      state_next.origin[`VTLCS_LOW_MSB:`VTLCS_LOW_LSB] = wbyte;
    end

    // lock bit, one-way option refuses a clear once set
    if (lock_wr_ok) begin
      if (one_way_lock_option && state_reg.locked && !wbyte[`VTLCS_FLAG_BIT]) begin
        state_next.locked = state_reg.locked;
      end else begin
        state_next.locked = wbyte[`VTLCS_FLAG_BIT];
      end
    end

    // bank select steers which saved context the shadow window shows
    if (wr_done && lane0 && hit_bank) begin
      state_next.bank_sel = wbyte[`VTLCS_FLAG_BIT];
    end

    // unlock sequence: any other completed write, except a repeated first key byte, breaks it
    if (wr_done) begin
      unique case (state_reg.key)
        VTLCS_KEY_IDLE: begin
          if (hit_key && lane0 && wbyte == `VTLCS_KEY_FIRST) begin
            state_next.key = VTLCS_KEY_FIRST_SEEN;
          end else begin
            state_next.key = VTLCS_KEY_IDLE;
          end
        end
        VTLCS_KEY_FIRST_SEEN: begin
          if (hit_key && lane0 && wbyte == `VTLCS_KEY_SECOND) begin
            state_next.key = VTLCS_KEY_ARMED;
          end else if (hit_key && lane0 && wbyte == `VTLCS_KEY_FIRST) begin
            state_next.key = VTLCS_KEY_FIRST_SEEN;
          end else begin
            state_next.key = VTLCS_KEY_IDLE;
          end
        end
        VTLCS_KEY_ARMED: begin
          // armed lasts for exactly one following write, whatever it hits
          state_next.key = VTLCS_KEY_IDLE;
        end
        default: begin
          state_next.key = VTLCS_KEY_IDLE;
        end
      endcase
    end else if (access_done && state_reg.pslverr) begin
      // an erroring access also breaks the sequence
      state_next.key = VTLCS_KEY_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // state flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.origin <= `VTLCS_ORIGIN_RST;
      state_reg.pointer <= `VTLCS_PTR_RST;
      state_reg.locked <= `VTLCS_LOCK_RST;
      state_reg.bank_sel <= `VTLCS_BANK_RST;
      state_reg.key <= VTLCS_KEY_IDLE;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata <= 32'h00000000;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign vector_table_origin = state_reg.origin;
  assign base_locked_flag = state_reg.locked;
  assign saved_context_bank_select = state_reg.bank_sel;

endmodule : vtlcs_top

// file: vtlcs_monitor.sv
// checker of the vector table lock and context select block ports
`timescale 1ns/1ps
`include "vtlcs_params.svh"
module vtlcs_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic one_way_lock_option,
  input wire logic [20:0] vector_table_origin,
  input wire logic base_locked_flag,
  input wire logic saved_context_bank_select
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  wire logic wr_done = psel && penable && pready && pwrite;
  // every register byte rides on lane 0, so only a strobed write may store
  wire logic wr_lane0 = wr_done && pstrb[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait_state: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_origin_locked: assert property (wr_done && base_locked_flag && paddr <= `VTLCS_OFS_ORIGIN_LOW
    |=> $stable(vector_table_origin)) else $error("locked origin moved");
  a_origin_low_wr: assert property (wr_lane0 && !base_locked_flag && paddr == `VTLCS_OFS_ORIGIN_LOW
    |=> vector_table_origin[7:0] == $past(pwdata[7:0])) else $error("origin low not written");
  a_lock_needs_wr: assert property ($changed(base_locked_flag) |-> $past(wr_done && paddr == `VTLCS_OFS_LOCK))
    else $error("lock moved without write");
  a_one_way_hold: assert property (one_way_lock_option && base_locked_flag |=> base_locked_flag)
    else $error("one-way lock cleared");
  a_bank_write: assert property (wr_lane0 && paddr == `VTLCS_OFS_BANK_CTL
    |=> saved_context_bank_select == $past(pwdata[0])) else $error("bank select not written");
  a_lock_read: assert property (pready && !pwrite && paddr == `VTLCS_OFS_LOCK
    |-> prdata == {31'h0, base_locked_flag}) else $error("lock read wrong");
  a_strobe_off_hold: assert property (wr_done && !pstrb[0]
    |=> $stable(vector_table_origin) && $stable(saved_context_bank_select) && $stable(base_locked_flag))
    else $error("unstrobed write stored");
endmodule : vtlcs_monitor

// file: tb_vtlcs_top.sv
// self-checking bench of the vector table lock and context select block
`timescale 1ns/1ps
`include "vtlcs_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_vtlcs_top import vtlcs_pkg::*; ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vload = 0, one_way = 0;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hF, strb = 4'hF;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [20:0] vin = 21'h0, origin;
  logic pready, pslverr, locked, bank;
  int err_count = 0, comparisons = 0;
  vtlcs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vector_pointer_load(vload), .vector_pointer_in(vin), .one_way_lock_option(one_way),
    .vector_table_origin(origin), .base_locked_flag(locked), .saved_context_bank_select(bank));
  initial forever #20 pclk = ~pclk;
  // ----------------------------------------------------------------
  // bus tasks, the master waits for pready
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= strb;
    @(posedge pclk);
    penable <= 1;
    // no local bound: a slave that never answers is caught by the watchdog
    do begin @(posedge pclk); end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1, a, d, r);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [32:0] r;
    apb(0, a, 32'h0, r);
    `CHK(r, {a > `VTLCS_OFS_UNLOCK_KEY, 24'h0, e})
  endtask : rd
  task automatic unlock;
    wr(`VTLCS_OFS_UNLOCK_KEY, 32'h55); wr(`VTLCS_OFS_UNLOCK_KEY, 32'hAA);
  endtask : unlock
  task automatic do_reset;
    presetn <= 0; repeat (3) @(posedge pclk); presetn <= 1;
  endtask : do_reset
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals;
    rd(`VTLCS_OFS_ORIGIN_UPPER, 8'h00); rd(`VTLCS_OFS_ORIGIN_HIGH, 8'h00); rd(`VTLCS_OFS_ORIGIN_LOW, 8'h08);
    rd(`VTLCS_OFS_PTR_UPPER, 8'h00);
    rd(`VTLCS_OFS_PTR_HIGH, 8'h00);
    rd(`VTLCS_OFS_PTR_LOW, 8'h08);
    rd(`VTLCS_OFS_LOCK, 8'h00); rd(`VTLCS_OFS_BANK_CTL, 8'h00);
  endtask : t_reset_vals
  task automatic t_pointer;
    @(posedge pclk); vload <= 1; vin <= 21'h1ABCDE;
    @(posedge pclk); vload <= 0;
    wr(`VTLCS_OFS_PTR_LOW, 32'h11); wr(`VTLCS_OFS_PTR_UPPER, 32'h11); // writes must not stick
    rd(`VTLCS_OFS_PTR_UPPER, 8'h1A);
    rd(`VTLCS_OFS_PTR_HIGH, 8'hBC);
    rd(`VTLCS_OFS_PTR_LOW, 8'hDE);
  endtask : t_pointer
  task automatic t_lock;
    wr(`VTLCS_OFS_ORIGIN_UPPER, 32'hFF); wr(`VTLCS_OFS_ORIGIN_HIGH, 32'h5A); wr(`VTLCS_OFS_ORIGIN_LOW, 32'hC3);
    @(negedge pclk); `CHK(origin, 21'h1F5AC3)
    wr(`VTLCS_OFS_LOCK, 32'h1); rd(`VTLCS_OFS_LOCK, 8'h00);
    unlock; wr(`VTLCS_OFS_LOCK, 32'h1); rd(`VTLCS_OFS_LOCK, 8'h01);
    wr(`VTLCS_OFS_ORIGIN_LOW, 32'h00); wr(`VTLCS_OFS_ORIGIN_UPPER, 32'h00);
    @(negedge pclk); `CHK(origin, 21'h1F5AC3)
    wr(`VTLCS_OFS_UNLOCK_KEY, 32'h55); wr(`VTLCS_OFS_BANK_CTL, 32'h0); wr(`VTLCS_OFS_UNLOCK_KEY, 32'hAA);
    wr(`VTLCS_OFS_LOCK, 32'h0); @(negedge pclk); `CHK(locked, 1'b1)
    // an errored access between key and lock cancels the sequence
    unlock; rd(12'h024, 8'h00); wr(`VTLCS_OFS_LOCK, 32'h0); @(negedge pclk); `CHK(locked, 1'b1)
    unlock; wr(`VTLCS_OFS_LOCK, 32'h0); @(negedge pclk); `CHK(locked, 1'b0)
    // a repeated first key byte keeps the sequence alive
    wr(`VTLCS_OFS_UNLOCK_KEY, 32'h55); unlock; wr(`VTLCS_OFS_LOCK, 32'h1); rd(`VTLCS_OFS_LOCK, 8'h01);
    unlock; wr(`VTLCS_OFS_LOCK, 32'h0); rd(`VTLCS_OFS_LOCK, 8'h00);
    wr(`VTLCS_OFS_ORIGIN_LOW, 32'h08); rd(`VTLCS_OFS_ORIGIN_LOW, 8'h08);
  endtask : t_lock
  task automatic t_one_way;
    @(posedge pclk); one_way <= 1;
    unlock; wr(`VTLCS_OFS_LOCK, 32'hFF); rd(`VTLCS_OFS_LOCK, 8'h01);
    unlock; wr(`VTLCS_OFS_LOCK, 32'h0); rd(`VTLCS_OFS_LOCK, 8'h01);
    do_reset; @(negedge pclk); `CHK(locked, 1'b0)
    @(posedge pclk); one_way <= 0;
    t_reset_vals;
  endtask : t_one_way
  task automatic t_bank;
    wr(`VTLCS_OFS_BANK_CTL, 32'hFF); rd(`VTLCS_OFS_BANK_CTL, 8'h01); `CHK(bank, 1'b1)
    // lane 0 strobe low must store nothing
    strb = 4'hE; wr(`VTLCS_OFS_BANK_CTL, 32'h00); strb = 4'hF;
    rd(`VTLCS_OFS_BANK_CTL, 8'h01); `CHK(bank, 1'b1)
    wr(`VTLCS_OFS_BANK_CTL, 32'hFE); rd(`VTLCS_OFS_BANK_CTL, 8'h00); `CHK(bank, 1'b0)
    rd(12'h024, 8'h00); rd(`VTLCS_OFS_UNLOCK_KEY, 8'h00);
  endtask : t_bank
  task automatic end_of_test;
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    do_reset;
    t_reset_vals; t_pointer; t_lock; t_one_way; t_bank;
    end_of_test;
  end
  // a hang counts as a mismatch; the sequence needs well under 20 us
  initial begin
    #200us; err_count++; end_of_test;
  end
endmodule : tb_vtlcs_top
bind vtlcs_top vtlcs_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr),
  .one_way_lock_option(one_way_lock_option), .vector_table_origin(vector_table_origin),
  .base_locked_flag(base_locked_flag), .saved_context_bank_select(saved_context_bank_select));
